// ===== ldc_pkg.sv
// Operation
// RULE1 - 216-bit config shift register; serial in at LSB, out from MSB.
// RULE2 - controller loads all config fields before enabling any output.
// RULE3 - gray-path config write places user bits into shift register bits 199-215.
// RULE4 - latch bits 0-167 hold one 7-bit correction value per channel.
// RULE5 - correction fields run red0, green0, blue0, red1 up to blue7.
// RULE6 - strobe copies shift register to latch 3-7 ms after last clock; the code copies it when the latch timer expires instead.
// RULE7 - correction spans 0-66.7% in low range, 33.3-100% in high range.
// RULE8 - brightness bits 175-168 red, 183-176 green, 191-184 blue.
// RULE9 - group brightness scales eight channels 0-100% in 256 steps.
// RULE10 - bits 192/193/194 pick red/green/blue correction range, 1 is high.
// RULE11 - without auto repeat each output cycles once after blank release.
// RULE12 - with auto repeat PWM restarts every 4096, 1024 or 256 clocks.
// RULE13 - timing reset: gray latch edge zeroes counter, outputs off.
// RULE14 - without timing reset controller blanks only after PWM ends.
// RULE15 - bits 198,197 select 12-, 10- or 8-bit grayscale counter.
// RULE16 - grayscale word stays 288 bits with 12-bit fields in every mode.
// RULE17 - outputs forced off at clock 256 or 1024 even for data up to fff.
// RULE18 - controller holds blank low from power-up; outputs then off.
// RULE19 - user bits drive no function, only pass between two controllers.
// RULE20 - strobe high at last gray clock copies bits 0-198 into the latch.
// RULE21 - latch timer restarts on every config clock rising edge.
package ldc_pkg;
  localparam int CFG_W  = 216;
  localparam int GRAY_W = 288;
  localparam int GS_W   = 12;
  localparam int NCH    = 24;
  localparam int NGRP   = 3;
  localparam int DC_W   = 7;
  localparam int BC_W   = 8;
  localparam int UD_LO  = 199;
  localparam int GCFG_HI = 198;
  localparam int NSYNC  = 9;

  localparam int CLK_MHZ       = 100;
  localparam int LATCH_MIN_US  = 3000;
  localparam int LATCH_MAX_US  = 7000;
  localparam int LATCH_MIN_CYC = LATCH_MIN_US * CLK_MHZ;
  localparam int LATCH_MAX_CYC = LATCH_MAX_US * CLK_MHZ;
  localparam int LATCH_DEF_CYC = (LATCH_MIN_CYC + LATCH_MAX_CYC) / 2;
  localparam int TMR_W         = 20;

  localparam int CNT_W = 13;
  localparam logic [CNT_W-1:0] PER_12 = 13'h1000;
  localparam logic [CNT_W-1:0] PER_10 = 13'h0400;
  localparam logic [CNT_W-1:0] PER_8  = 13'h0100;

  localparam int CUR_W = 9;
  localparam logic [CUR_W-1:0] DC_HI_BASE = 9'h07f;
  localparam logic [BC_W-1:0]  BC_FULL    = 8'hff;

  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_LATCH0 = 8'h10;
  localparam int LATCH_WORDS = 7;
  localparam int CTRL_SW_BLANK = 0;
  localparam int ST_PEND   = 0;
  localparam int ST_RUN_LO = 1;

  typedef struct packed {
    logic [1:0]      cnt_mode;
    logic            timing_reset;
    logic            auto_repeat;
    logic [NGRP-1:0] hi_range;
  } ldc_fc_t;

  typedef struct packed {
    logic [16:0]               user_bits;
    ldc_fc_t                   fc;
    logic [NGRP-1:0][BC_W-1:0] bc;
    logic [NCH-1:0][DC_W-1:0]  dc;
  } ldc_cfg_t;

  typedef enum logic [1:0] {
    PWM_IDLE = 2'b00,
    PWM_RUN  = 2'b01,
    PWM_DONE = 2'b10
  } ldc_pwm_state_t;

  function automatic logic [CNT_W-1:0] ldc_period(input logic [1:0] mode);
    if (!mode[1]) begin
      return PER_12;
    end else if (!mode[0]) begin
      return PER_10;
    end
    return PER_8;
  endfunction
endpackage

// ===== ldc_chan_current.sv
`timescale 1ns/10ps
module ldc_chan_current (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic [ldc_pkg::DC_W-1:0]    dc,
  input  wire logic                        hi_range,
  input  wire logic [ldc_pkg::BC_W-1:0]    bc,
  output logic      [ldc_pkg::CUR_W-1:0]   cur_q
);
  // full scale is 381 = 3 x 127, so both ranges land on exact thirds
  logic [ldc_pkg::CUR_W-1:0] corr;
  logic [16:0]               prod;

  always_comb begin
    corr = (hi_range ? ldc_pkg::DC_HI_BASE : 9'h000) + // [RULE7]
           {1'b0, dc, 1'b0};
    prod = corr * {9'h000, bc};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_q <= '0;
    end else begin
      cur_q <= ldc_pkg::CUR_W'(prod / {9'h000, ldc_pkg::BC_FULL}); // [RULE9]
    end
  end

  hi_floor_a: assert property (@(posedge pclk) // [RULE7]
    disable iff (!presetn)
    (hi_range && dc == 7'h00 && bc == ldc_pkg::BC_FULL) |=>
      cur_q == ldc_pkg::DC_HI_BASE)
    else $error("high range floor is not one third");
  bc_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE9]
    (bc == 8'h00) |=> cur_q == 9'h000)
    else $error("zero brightness leaves current on");
endmodule

// ===== ldc_config_latch.sv
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/10ps
module ldc_config_latch #(
  parameter int LATCH_CYC = ldc_pkg::LATCH_DEF_CYC
) (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic [ldc_pkg::ADDR_W-1:0]    paddr,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          config_serial_in,
  input  wire logic                          config_serial_clock,
  output logic                               config_serial_out,
  input  wire logic                          gray_serial_in,
  input  wire logic                          gray_serial_clock,
  input  wire logic                          gray_latch_strobe,
  output logic                               gray_serial_out,
  input  wire logic                          output_blank_n,
  input  wire logic [ldc_pkg::NGRP-1:0]      group_pwm_clocks,
  output logic      [ldc_pkg::NCH-1:0]       channel_on,
  output logic [ldc_pkg::NCH-1:0][ldc_pkg::CUR_W-1:0] channel_current,
  output ldc_pkg::ldc_cfg_t                  config_latch
);
  localparam int CW = ldc_pkg::CFG_W;
  localparam int GW = ldc_pkg::GRAY_W;
  localparam int NG = ldc_pkg::NGRP;
  localparam int KW = ldc_pkg::CNT_W;

  // pin synchronisers; s1 feeds only s2
  logic [ldc_pkg::NSYNC-1:0] s1_q;
  logic [ldc_pkg::NSYNC-1:0] s2_q;
  logic [ldc_pkg::NSYNC-1:0] prev_q;
  logic cfg_din;
  logic cfg_clk;
  logic gry_din;
  logic gry_clk;
  logic gry_stb;
  logic blank_pin_n;
  logic [NG-1:0] grp_clk;
  logic [NG-1:0] grp_rise;
  logic cfg_clk_rise;
  logic gry_clk_rise;
  logic gry_stb_rise;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q   <= '0;
      s2_q   <= '0;
      prev_q <= '0;
    end else begin
      s1_q   <= {config_serial_in, config_serial_clock, gray_serial_in,
                 gray_serial_clock, gray_latch_strobe, output_blank_n,
                 group_pwm_clocks};
      s2_q   <= s1_q;
      prev_q <= s2_q;
    end
  end

  assign {cfg_din, cfg_clk, gry_din, gry_clk, gry_stb, blank_pin_n,
          grp_clk} = s2_q;
  assign cfg_clk_rise = cfg_clk & ~prev_q[7];
  assign gry_clk_rise = gry_clk & ~prev_q[5];
  assign gry_stb_rise = gry_stb & ~prev_q[4];
  assign grp_rise     = grp_clk & ~prev_q[NG-1:0];

  // grayscale common shift path
  logic [GW-1:0] gray_sr_q;
  logic [GW-1:0] gray_lat_q;
  logic          stb_at_clk_q;
  logic          gray_to_cfg;
  logic          gs_write;

  assign gray_to_cfg = gry_stb_rise & stb_at_clk_q; // [RULE20]
  assign gs_write    = gry_stb_rise & ~stb_at_clk_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gray_sr_q    <= '0;
      stb_at_clk_q <= 1'b0;
    end else if (gry_clk_rise) begin
      gray_sr_q    <= {gray_sr_q[GW-2:0], gry_din};
      stb_at_clk_q <= gry_stb;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gray_lat_q <= '0;
    end else if (gs_write) begin
      gray_lat_q <= gray_sr_q; // [RULE16]
    end
  end

  assign gray_serial_out = gray_sr_q[GW-1];

  // configuration shift register and latch timer
  logic [CW-1:0]               cfg_sr_q;
  logic [ldc_pkg::TMR_W-1:0]   tmr_q;
  logic                        pend_q;
  logic                        latch_copy;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_sr_q <= '0;
    end else begin
      if (cfg_clk_rise) begin
        cfg_sr_q <= {cfg_sr_q[CW-2:0], cfg_din}; // [RULE1]
      end
      if (gray_to_cfg) begin
        cfg_sr_q[CW-1:ldc_pkg::UD_LO] <= // [RULE3]
          gray_sr_q[CW-1:ldc_pkg::UD_LO];
      end
    end
  end

  assign config_serial_out = cfg_sr_q[CW-1]; // [RULE1]

  assign latch_copy = pend_q & ~cfg_clk_rise &
                      (tmr_q == ldc_pkg::TMR_W'(LATCH_CYC - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_q  <= '0;
      pend_q <= 1'b0;
    end else if (cfg_clk_rise) begin
      tmr_q  <= '0; // [RULE21]
      pend_q <= 1'b1;
    end else if (latch_copy) begin
      pend_q <= 1'b0; // [RULE6]
    end else if (pend_q) begin
      tmr_q  <= tmr_q + 1'b1;
    end
  end

  // a gray-path copy after the strobe wins over a colliding timer copy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_latch <= '0;
    end else if (gray_to_cfg) begin
      config_latch[ldc_pkg::GCFG_HI:0] <= // [RULE20]
        gray_sr_q[ldc_pkg::GCFG_HI:0];
    end else if (latch_copy) begin
      config_latch <= cfg_sr_q; // [RULE6]
    end
  end

  // software blank, status and readback over apb
  logic        sw_blank_q;
  logic [31:0] rd_q;
  logic [NG-1:0] run_w;
  logic        blank_ok;

  function automatic logic addr_ok(input logic [ldc_pkg::ADDR_W-1:0] a,
                                   input logic wr);
    logic [ldc_pkg::ADDR_W-1:0] top;
    top = ldc_pkg::REG_LATCH0 + ldc_pkg::ADDR_W'(4 * ldc_pkg::LATCH_WORDS);
    if (a[1:0] != 2'b00) begin
      return 1'b0;
    end else if (a == ldc_pkg::REG_CTRL) begin
      return 1'b1;
    end else if (wr) begin
      return 1'b0;
    end
    return (a == ldc_pkg::REG_STATUS) ||
           (a >= ldc_pkg::REG_LATCH0 && a < top);
  endfunction

  function automatic logic [31:0] rd_mux(input logic [ldc_pkg::ADDR_W-1:0] a,
                                         input logic [CW-1:0] lat,
                                         input logic sb,
                                         input logic pd,
                                         input logic [NG-1:0] rn);
    logic [8*ldc_pkg::LATCH_WORDS*4-1:0] pad;
    logic [ldc_pkg::ADDR_W-1:0]          idx;
    pad = {8'h00, lat};
    idx = (a - ldc_pkg::REG_LATCH0) >> 2;
    if (a == ldc_pkg::REG_CTRL) begin
      return {31'h0, sb};
    end else if (a == ldc_pkg::REG_STATUS) begin
      return {28'h0, rn, pd};
    end
    return pad[idx[2:0]*32 +: 32];
  endfunction

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok(paddr, pwrite);
  assign prdata  = rd_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_blank_q <= 1'b1;
    end else if (psel && penable && pwrite && paddr == ldc_pkg::REG_CTRL) begin
      sw_blank_q <= pwdata[ldc_pkg::CTRL_SW_BLANK];
    end
  end

  // read data is captured in the setup cycle so the access phase has no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_q <= '0;
    end else if (psel && !penable && !pwrite) begin
      rd_q <= addr_ok(paddr, 1'b0) ?
              rd_mux(paddr, config_latch, sw_blank_q, pend_q, run_w) : 32'h0;
    end
  end

  // grayscale pwm, one counter per colour group
  logic [NG-1:0][KW-1:0] cnt_w;
  logic [KW-1:0]         period;
  logic                  tr_clear;
  logic [ldc_pkg::NCH-1:0] on_d;

  assign period   = ldc_pkg::ldc_period(config_latch.fc.cnt_mode); // [RULE15]
  assign tr_clear = gs_write & config_latch.fc.timing_reset; // [RULE13]
  assign blank_ok = blank_pin_n & ~sw_blank_q; // [RULE18]

  genvar g;
  generate
    for (g = 0; g < NG; g++) begin : g_grp
      ldc_pkg::ldc_pwm_state_t st_q;
      logic [KW-1:0]           cnt_q;

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          st_q  <= ldc_pkg::PWM_IDLE;
          cnt_q <= '0;
        end else if (!blank_ok || tr_clear) begin
          st_q  <= ldc_pkg::PWM_IDLE; // [RULE13]
          cnt_q <= '0;
        end else if (grp_rise[g]) begin
          case (st_q)
            ldc_pkg::PWM_IDLE: begin
              st_q  <= ldc_pkg::PWM_RUN;
              cnt_q <= '0;
            end
            ldc_pkg::PWM_RUN: begin
              if (cnt_q >= period - 1'b1) begin
                if (config_latch.fc.auto_repeat) begin
                  cnt_q <= '0; // [RULE12]
                end else begin
                  st_q  <= ldc_pkg::PWM_DONE; // [RULE11]
                  cnt_q <= period;
                end
              end else begin
                cnt_q <= cnt_q + 1'b1;
              end
            end
            ldc_pkg::PWM_DONE: begin
              st_q <= ldc_pkg::PWM_DONE; // [RULE11]
            end
            default: begin
              st_q <= ldc_pkg::PWM_IDLE;
            end
          endcase
        end
      end

      assign run_w[g] = (st_q == ldc_pkg::PWM_RUN);
      assign cnt_w[g] = cnt_q;
    end

    for (g = 0; g < ldc_pkg::NCH; g++) begin : g_ch
      localparam int GRP = g % NG; // [RULE5]
      logic [ldc_pkg::GS_W-1:0] gs;
      assign gs = gray_lat_q[g*ldc_pkg::GS_W +: ldc_pkg::GS_W];
      // full 12-bit compare, cut by the period in the short modes
      assign on_d[g] = blank_ok & ~tr_clear & run_w[GRP] &
                       (cnt_w[GRP] < {1'b0, gs}) &
                       (cnt_w[GRP] < period); // [RULE17]

      ldc_chan_current u_cur (
        .pclk     (pclk),
        .presetn  (presetn),
        .dc       (config_latch.dc[g]), // [RULE4]
        .hi_range (config_latch.fc.hi_range[GRP]), // [RULE10]
        .bc       (config_latch.bc[GRP]), // [RULE8]
        .cur_q    (channel_current[g])
      );
    end
  endgenerate

  // user bits are stored and read back only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_on <= '0;
    end else begin
      channel_on <= on_d; // [RULE19]
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  shift_in_a: assert property (cfg_clk_rise |=> // [RULE1]
    cfg_sr_q[0] == $past(cfg_din) &&
    config_serial_out == $past(cfg_sr_q[CW-2]))
    else $error("config shift register did not shift");
  timer_restart_a: assert property (cfg_clk_rise |=> // [RULE21]
    pend_q && tmr_q == '0)
    else $error("latch timer did not restart");
  timer_copy_a: assert property (latch_copy && !gray_to_cfg |=> // [RULE6]
    config_latch == $past(cfg_sr_q) && !pend_q)
    else $error("timer copy did not load latch");
  timer_bound_a: assert property (pend_q |-> // [RULE6]
    tmr_q <= ldc_pkg::TMR_W'(LATCH_CYC - 1))
    else $error("latch timer overran its delay");
  gray_copy_a: assert property (gray_to_cfg |=> // [RULE20]
    config_latch[ldc_pkg::GCFG_HI:0] ==
      $past(gray_sr_q[ldc_pkg::GCFG_HI:0]) &&
    cfg_sr_q[CW-1:ldc_pkg::UD_LO] == $past(gray_sr_q[CW-1:ldc_pkg::UD_LO]))
    else $error("gray path copy wrong"); // [RULE3]
  blank_off_a: assert property (!blank_ok |=> channel_on == '0 ##1 // [RULE18]
    (!run_w[0] || blank_ok))
    else $error("outputs on while blanked");
  tr_reset_a: assert property (tr_clear |=> // [RULE13]
    channel_on == '0 && cnt_w == '0 && run_w == '0)
    else $error("timing reset did not clear pwm");
  period_off_a: assert property (channel_on[0] |-> // [RULE17]
    $past(cnt_w[0]) < $past(period))
    else $error("red0 on past counter period");
  wrap_a: assert property (grp_rise[0] && run_w[0] && blank_ok && // [RULE12]
    !tr_clear && cnt_w[0] == period - 1'b1 &&
    config_latch.fc.auto_repeat |=>
      run_w[0] && cnt_w[0] == '0)
    else $error("auto repeat did not restart");
  once_a: assert property (grp_rise[0] && run_w[0] && blank_ok && // [RULE11]
    !tr_clear && cnt_w[0] == period - 1'b1 &&
    !config_latch.fc.auto_repeat |=>
      !run_w[0] [*2])
    else $error("single shot pwm restarted");
  apb_err_a: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");

  timer_copy_c: cover property (latch_copy);
  gray_copy_c: cover property (gray_to_cfg);
  wrap_c: cover property (run_w[0] && config_latch.fc.auto_repeat
    ##1 cnt_w[0] == '0 && $past(cnt_w[0]) != '0);
  tr_clear_c: cover property (tr_clear && run_w != '0);
endmodule

// ===== ldc_dummy_unused_marker_never.sv
`timescale 1ns/10ps

// ===== ldc_ctrl_model.sv
`timescale 1ns/10ps
module ldc_ctrl_model (
  output logic config_serial_in,
  output logic config_serial_clock,
  output logic gray_serial_in,
  output logic gray_serial_clock,
  output logic gray_latch_strobe
);
  // both link clocks stand still low between frames
  initial begin
    config_serial_in    = 1'b0;
    config_serial_clock = 1'b0;
    gray_serial_in      = 1'b0;
    gray_serial_clock   = 1'b0;
    gray_latch_strobe   = 1'b0;
  end

  // hp is the half period in ns; a slow link stretches it
  task automatic cfg_frame(input logic [215:0] w, input int hp);
    #3;
    for (int i = 215; i >= 0; i--) begin
      config_serial_in = w[i]; // msb first, first bit ends at 215
      #(hp);
      config_serial_clock = 1'b1;
      #(hp);
      config_serial_clock = 1'b0;
    end
    // released line flips so a stale bit is never mistaken for data
    config_serial_in = ~w[0];
  endtask

  task automatic gray_frame(input logic [287:0] g, input logic to_cfg);
    #3;
    for (int i = 287; i >= 0; i--) begin
      gray_serial_in = g[i];
      if (i == 0) begin
        gray_latch_strobe = to_cfg; // level at last clock picks latch
      end
      #80;
      gray_serial_clock = 1'b1;
      #80;
      gray_serial_clock = 1'b0;
    end
    gray_serial_in    = ~g[0];
    gray_latch_strobe = 1'b0;
    #80;
    gray_latch_strobe = 1'b1;
    #80;
    gray_latch_strobe = 1'b0;
  endtask
endmodule

// ===== tb_top.sv
`timescale 1ns/10ps
module tb_top;
  localparam int LCYC = 50;
  typedef struct packed {
    logic        rd;
    logic        err;
    logic [31:0] data;
  } ldc_exp_t;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata;
  logic              config_serial_in, config_serial_clock, config_serial_out;
  logic              gray_serial_in, gray_serial_clock, gray_latch_strobe;
  logic              gray_serial_out, output_blank_n;
  logic [2:0]        group_pwm_clocks;
  logic [23:0]       channel_on;
  logic [23:0][8:0]  channel_current;
  ldc_pkg::ldc_cfg_t cfg_latch;
  ldc_exp_t          exp_q[$];
  ldc_exp_t          mon_e;
  logic [215:0]      w, w2;
  logic [287:0]      g, gdat;
  logic [6:0]        dcv;
  logic [7:0]        bcv;
  int                ecur;
  integer            seed = 32'hb214;
  int                fail_count = 0;
  int                tests_run = 0;
  logic [1:0]        modes[6] = '{2'b11, 2'b10, 2'b00, 2'b01, 2'b11, 2'b11};
  int                pers[6] = '{256, 1024, 4096, 4096, 256, 256};

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  ldc_config_latch #(.LATCH_CYC(LCYC)) uut (
    .pclk                (pclk),
    .presetn             (presetn),
    .paddr               (paddr),
    .psel                (psel),
    .penable             (penable),
    .pwrite              (pwrite),
    .pwdata              (pwdata),
    .prdata              (prdata),
    .pready              (pready),
    .pslverr             (pslverr),
    .config_serial_in    (config_serial_in),
    .config_serial_clock (config_serial_clock),
    .config_serial_out   (config_serial_out),
    .gray_serial_in      (gray_serial_in),
    .gray_serial_clock   (gray_serial_clock),
    .gray_latch_strobe   (gray_latch_strobe),
    .gray_serial_out     (gray_serial_out),
    .output_blank_n      (output_blank_n),
    .group_pwm_clocks    (group_pwm_clocks),
    .channel_on          (channel_on),
    .channel_current     (channel_current),
    .config_latch        (cfg_latch)
  );

  ldc_ctrl_model ctl (
    .config_serial_in    (config_serial_in),
    .config_serial_clock (config_serial_clock),
    .gray_serial_in      (gray_serial_in),
    .gray_serial_clock   (gray_serial_clock),
    .gray_latch_strobe   (gray_latch_strobe)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // d is write data, or the expected read data
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic err);
    int n;
    exp_q.push_back('{rd: !wr, err: err, data: d});
    @(posedge pclk);
    psel   <= 1'b1;
    paddr  <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      fail_count++;
      stop_test();
    end
  endtask

  task automatic read_latch(input logic [215:0] v);
    for (int k = 0; k < 7; k++) begin
      apb(1'b0, 8'h10 + 8'(4 * k), 32'(v >> (32 * k)),
          1'b0);
    end
  endtask

  // 2 pclk high, 2 low keeps each level visible past the synchronisers
  task automatic gpulse(input int n);
    @(posedge pclk);
    repeat (n) begin
      group_pwm_clocks <= 3'b111;
      cyc(2);
      group_pwm_clocks <= 3'b000;
      cyc(2);
    end
    cyc(6);
  endtask

  function automatic logic [215:0] rnd216();
    logic [223:0] r;
    for (int i = 0; i < 7; i++) begin
      r = {r[191:0], 32'($random(seed))};
    end
    return r[215:0];
  endfunction

  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      if (exp_q.size() == 0) begin
        check(32'(pslverr), 32'h2);
      end else begin
        mon_e = exp_q.pop_front();
        check(32'(pslverr), 32'(mon_e.err));
        if (mon_e.rd) begin
          check(prdata, mon_e.data);
        end
      end
    end
  end

  initial begin
    presetn          = 1'b0;
    psel             = 1'b0;
    penable          = 1'b0;
    pwrite           = 1'b0;
    paddr            = 8'h00;
    pwdata           = 32'h0;
    output_blank_n   = 1'b0; // dark from power-up
    group_pwm_clocks = 3'b000;
    cyc(2);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h1, 1'b0);
    apb(1'b0, 8'h04, 32'h0, 1'b0);
    read_latch('0);
    apb(1'b0, 8'h2c, 32'h0, 1'b1);
    apb(1'b0, 8'h02, 32'h0, 1'b1);
    apb(1'b1, 8'h10, 32'hffffffff, 1'b1);
    apb(1'b1, 8'h04, 32'h0000000f, 1'b1);
    apb(1'b0, 8'h10, 32'h0, 1'b0);
    $display("test reset and map done");

    w = rnd216();
    ctl.cfg_frame(w, 80);
    apb(1'b0, 8'h04, 32'h1, 1'b0);
    cyc(LCYC - 16);
    apb(1'b0, 8'h10, 32'h0, 1'b0);
    cyc(10);
    read_latch(w);
    apb(1'b0, 8'h04, 32'h0, 1'b0);
    check(32'(config_serial_out), 32'(w[215]));
    check(32'(cfg_latch.dc[1]), 32'(w[13:7]));
    check(32'(cfg_latch.dc[23]), 32'(w[167:161]));
    check(32'(cfg_latch.bc[0]), 32'(w[175:168]));
    check(32'(cfg_latch.bc[2]), 32'(w[191:184]));
    check(32'(cfg_latch.fc.hi_range), 32'(w[194:192]));
    check(32'(cfg_latch.fc.cnt_mode), 32'(w[198:197]));
    check(32'(cfg_latch.user_bits), 32'(w[215:199]));
    $display("test config frame done");

    w2 = rnd216();
    ctl.cfg_frame(w2, 150);
    read_latch(w);
    cyc(LCYC); // gap beyond the copy window before a gray write
    read_latch(w2);
    $display("test slow frame done");

    g = {rnd216(), 72'(rnd216())};
    ctl.gray_frame(g, 1'b1);
    cyc(8);
    read_latch({w2[215:199], g[198:0]});
    check(32'(config_serial_out), 32'(g[215]));
    check(32'(gray_serial_out), 32'(g[287]));
    cyc(2 * LCYC);
    apb(1'b0, 8'h10, g[31:0], 1'b0);
    $display("test gray config done");

    // red0 value fff above every short mode maximum, green0 at 010 below them
    gdat = {264'h0, 12'h010, 12'hfff};
    ctl.gray_frame(gdat, 1'b0);
    apb(1'b1, 8'h00, 32'h0, 1'b0); // enable only once configured
    apb(1'b0, 8'h00, 32'h0, 1'b0);
    for (int c = 0; c < 6; c++) begin
      @(posedge pclk);
      output_blank_n <= 1'b0; // blank once the period is over
      dcv = 7'($random(seed));
      bcv = 8'($random(seed));
      w = {17'h0, modes[c], c == 5, c >= 4, {3{c[0]}}, {3{bcv}}, {24{dcv}}};
      ecur = ((c[0] ? 127 : 0) + 2 * int'(dcv)) * int'(bcv) / 255;
      ctl.cfg_frame(w, 80);
      cyc(LCYC + 10);
      gpulse(10);
      check(32'(channel_on), 32'h0);
      output_blank_n <= 1'b1;
      gpulse(pers[c] - 6);
      check(32'(channel_on[1:0]), 32'h1);
      check(32'(channel_current[0]), 32'(ecur));
      if (c == 5) begin
        ctl.gray_frame(gdat, 1'b0);
        cyc(6);
        check(32'(channel_on[1:0]), 32'h0);
        gpulse(1);
        check(32'(channel_on[1:0]), 32'h3);
      end else begin
        gpulse(11);
        check(32'(channel_on[1:0]),
              c == 4 ? 32'h3 : 32'h0);
      end
      $display("test pwm case %0d done", c);
    end
    stop_test();
  end
endmodule
